// [rtl/fcr_clock_pin_ctl.sv]
// Purpose: drive control for the bus clock pin
// Assumes: mode and state pins are asynchronous, synchronised here
// Notes: outputs are flops; latency three cycles from pins
`timescale 1ns/1ns
module fcr_clock_pin_ctl
    import fcr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic clockPinOutputEnable,
    input wire logic [2:0] clockModePins,
    input wire logic processorStatePinHi,
    input wire logic processorStatePinLo,
    output logic busClockPinOe,
    output logic busClockHoldLow
);
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic [2:0] mode;
    logic hi;
    logic lo;

    // =====================================================
    // two-stage synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA <= 5'h00;
            syncB <= 5'h00;
        end else begin
            syncA <= {clockModePins, processorStatePinHi, processorStatePinLo};
            syncB <= syncA;
        end
    end

    assign mode = syncB[4:2];
    assign hi = syncB[1];
    assign lo = syncB[0];

    // =====================================================
    // pin drive
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busClockPinOe <= 1'b1;
            busClockHoldLow <= 1'b0;
        end else begin
            busClockPinOe <= (mode != FCR_MODE_EXT_CLOCK);
            busClockHoldLow <= (mode != FCR_MODE_EXT_CLOCK) && !clockPinOutputEnable && !hi && lo;
        end
    end

    chk_pin_drives_clock: assert property (@(posedge clk) disable iff (!rstn)
        (clockPinOutputEnable && mode != FCR_MODE_EXT_CLOCK) |=> (busClockPinOe && !busClockHoldLow))
        else $error("clock pin not driving clock");
    chk_pin_held_low: assert property (@(posedge clk) disable iff (!rstn)
        (!clockPinOutputEnable && !hi && lo && mode != FCR_MODE_EXT_CLOCK) |=> busClockHoldLow)
        else $error("clock pin not held low");
    chk_pin_input_mode: assert property (@(posedge clk) disable iff (!rstn)
        (mode == FCR_MODE_EXT_CLOCK) |=> (!busClockPinOe && !busClockHoldLow))
        else $error("clock pin driven in mode 7");
endmodule : fcr_clock_pin_ctl

// [rtl/fcr_frequency_control.sv]
// Purpose: frequency control register with Avalon-MM slave and settling sequencer
// Assumes: watchdog overflow arrives on clk
// Notes: active settings are what the clock generator uses
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module fcr_frequency_control
    import fcr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic watchdogOverflow,
    input wire logic [2:0] clockModePins,
    input wire logic processorStatePinHi,
    input wire logic processorStatePinLo,
    output logic busClockPinOe,
    output logic busClockHoldLow,
    output logic [1:0] pllMultiplier,
    output logic [1:0] coreDivider,
    output logic [1:0] periphDivider,
    output logic processorPause,
    output logic clocksStopped,
    output logic watchdogStart
);
    logic [15:0] frequencyControl;
    fcr_state_e state;
    logic accept;
    logic regHit;
    logic wordAccess;
    logic regWrite;
    logic [15:0] next_frequencyControl;
    logic [15:0] settleSource;

    function automatic logic [1:0] field2(input logic [15:0] v, input int lsb);
        field2 = v[lsb +: 2];
    endfunction : field2

    // =====================================================
    // bus slave: one wait cycle, answer when waitrequest low
    assign accept = (read || write) && !waitrequest;
    assign regHit = (address == FCR_ADDR_FREQ_CONTROL);
    assign wordAccess = (byteenable[1:0] == FCR_WORD_BYTES[1:0]);
    assign regWrite = accept && write && regHit && wordAccess;
    assign next_frequencyControl = writedata[15:0] & FCR_WRITE_MASK;
    assign settleSource = regWrite ? next_frequencyControl : frequencyControl;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            waitrequest <= 1'b1;
        end else if (waitrequest && (read || write)) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            readdata <= 32'h00000000;
        end else if (waitrequest && read && regHit && wordAccess) begin
            readdata <= {16'h0000, frequencyControl & FCR_WRITE_MASK};
        end else if (waitrequest && read) begin
            readdata <= 32'h00000000;
        end
    end

    // =====================================================
    // register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frequencyControl <= FCR_RESET_VALUE;
        end else if (regWrite) begin
            frequencyControl <= next_frequencyControl;
        end
    end

    // =====================================================
    // settling sequencer and active settings
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= FCR_RUN;
            pllMultiplier <= FCR_RESET_VALUE[FCR_MUL_LSB +: 2];
            coreDivider <= FCR_RESET_VALUE[FCR_CORE_LSB +: 2];
            periphDivider <= FCR_RESET_VALUE[FCR_PERIPH_LSB +: 2];
            processorPause <= 1'b0;
            clocksStopped <= 1'b0;
            watchdogStart <= 1'b0;
        end else begin
            watchdogStart <= 1'b0;
            case (state)
                FCR_RUN: begin
                    if (regWrite && field2(next_frequencyControl, FCR_MUL_LSB) != pllMultiplier) begin
                        state <= FCR_SETTLE;
                        processorPause <= 1'b1;
                        clocksStopped <= 1'b1;
                        watchdogStart <= 1'b1;
                    end else if (regWrite) begin
                        coreDivider <= field2(next_frequencyControl, FCR_CORE_LSB);
                        periphDivider <= field2(next_frequencyControl, FCR_PERIPH_LSB);
                    end
                end
                FCR_SETTLE: begin
                    if (watchdogOverflow) begin
                        state <= FCR_RUN;
                        pllMultiplier <= field2(settleSource, FCR_MUL_LSB);
                        coreDivider <= field2(settleSource, FCR_CORE_LSB);
                        periphDivider <= field2(settleSource, FCR_PERIPH_LSB);
                        processorPause <= 1'b0;
                        clocksStopped <= 1'b0;
                    end
                end
                default: begin
                    state <= FCR_RUN;
                    processorPause <= 1'b0;
                    clocksStopped <= 1'b0;
                end
            endcase
        end
    end

    fcr_clock_pin_ctl pinCtl (
        .clk(clk),
        .rstn(rstn),
        .clockPinOutputEnable(frequencyControl[FCR_CLOCK_OE_BIT]),
        .clockModePins(clockModePins),
        .processorStatePinHi(processorStatePinHi),
        .processorStatePinLo(processorStatePinLo),
        .busClockPinOe(busClockPinOe),
        .busClockHoldLow(busClockHoldLow)
    );

    // =====================================================
    // checks
    sequence mulWrite;
        state == FCR_RUN && regWrite && next_frequencyControl[FCR_MUL_LSB +: 2] != pllMultiplier;
    endsequence
    sequence settled;
        state == FCR_SETTLE && watchdogOverflow;
    endsequence
    sequence busAnswer;
        !waitrequest ##1 waitrequest;
    endsequence

    chk_byte_write_ignored: assert property (@(posedge clk) disable iff (!rstn)
        (accept && write && !wordAccess) |=> $stable(frequencyControl))
        else $error("partial write changed register");
    chk_byte_read_zero: assert property (@(posedge clk) disable iff (!rstn)
        (waitrequest && read && !(regHit && wordAccess)) |=> (readdata == 32'h00000000))
        else $error("refused read returned data");
    chk_bus_one_wait: assert property (@(posedge clk) disable iff (!rstn)
        ((read || write) && waitrequest) |=> busAnswer)
        else $error("bus answer not one cycle");
    chk_reserved_read_zero: assert property (@(posedge clk) disable iff (!rstn)
        (readdata[31:13] == 19'h00000) && (readdata[11:10] == 2'h0) && (readdata[7:6] == 2'h0)
        && (readdata[3:2] == 2'h0))
        else $error("reserved bits read nonzero");
    chk_register_reserved: assert property (@(posedge clk) disable iff (!rstn)
        (frequencyControl & ~FCR_WRITE_MASK) == 16'h0000)
        else $error("reserved bits stored");
    chk_word_write_all: assert property (@(posedge clk) disable iff (!rstn)
        regWrite |=> (frequencyControl == ($past(writedata[15:0]) & FCR_WRITE_MASK)))
        else $error("word write did not update all fields");
    chk_oe_bit_written: assert property (@(posedge clk) disable iff (!rstn)
        regWrite |=> (frequencyControl[FCR_CLOCK_OE_BIT] == $past(writedata[FCR_CLOCK_OE_BIT])))
        else $error("pin enable bit not written");
    chk_read_answer: assert property (@(posedge clk) disable iff (!rstn)
        (waitrequest && read && regHit && wordAccess) |=> (!waitrequest && readdata[15:0] == frequencyControl))
        else $error("read answer wrong");

    // =====================================================
    // sequencer checks
    chk_settle_entry: assert property (@(posedge clk) disable iff (!rstn)
        mulWrite |=> (processorPause && clocksStopped && watchdogStart ##1 !watchdogStart))
        else $error("multiplier change did not pause");
    chk_settle_exit: assert property (@(posedge clk) disable iff (!rstn)
        settled |=> (!processorPause && !clocksStopped && pllMultiplier == frequencyControl[FCR_MUL_LSB +: 2]))
        else $error("settling exit wrong");
    chk_divider_direct: assert property (@(posedge clk) disable iff (!rstn)
        (state == FCR_RUN && regWrite && next_frequencyControl[FCR_MUL_LSB +: 2] == pllMultiplier)
        |=> (!processorPause
        && coreDivider == frequencyControl[FCR_CORE_LSB +: 2]
        && periphDivider == frequencyControl[FCR_PERIPH_LSB +: 2]))
        else $error("divider change not immediate");
    chk_divider_no_start: assert property (@(posedge clk) disable iff (!rstn)
        (state == FCR_RUN && regWrite && next_frequencyControl[FCR_MUL_LSB +: 2] == pllMultiplier)
        |=> (!watchdogStart && state == FCR_RUN))
        else $error("divider change started settling");
    chk_pause_holds: assert property (@(posedge clk) disable iff (!rstn)
        (state == FCR_SETTLE && !watchdogOverflow) |=> processorPause)
        else $error("pause dropped before overflow");
    chk_settle_holds_actives: assert property (@(posedge clk) disable iff (!rstn)
        (state == FCR_SETTLE && !watchdogOverflow) |=> $stable({pllMultiplier, coreDivider, periphDivider}))
        else $error("active settings moved while settling");
    chk_overflow_ignored: assert property (@(posedge clk) disable iff (!rstn)
        (state == FCR_RUN && watchdogOverflow && !regWrite) |=> ($stable(pllMultiplier) && !processorPause))
        else $error("stray overflow acted");
    chk_start_pulse_cause: assert property (@(posedge clk) disable iff (!rstn)
        watchdogStart |-> (processorPause && clocksStopped && state == FCR_SETTLE))
        else $error("watchdog start outside settling");
    chk_stopped_with_pause: assert property (@(posedge clk) disable iff (!rstn)
        clocksStopped == processorPause)
        else $error("clock stop and pause disagree");
endmodule : fcr_frequency_control

// [rtl/fcr_pkg.sv]
// Purpose: constants for the frequency control register block
// Assumes: 16-bit register in the low half of a 32-bit Avalon-MM word
// Notes: one register, word aligned
package fcr_pkg;
    // =====================================================
    // register map
    localparam logic [3:0] FCR_ADDR_FREQ_CONTROL = 4'h0;
    localparam logic [15:0] FCR_RESET_VALUE = 16'h1003;
    localparam logic [15:0] FCR_WRITE_MASK = 16'h1333;
    localparam logic [3:0] FCR_WORD_BYTES = 4'h3;
    // =====================================================
    // field positions
    localparam int FCR_CLOCK_OE_BIT = 12;
    localparam int FCR_MUL_LSB = 8;
    localparam int FCR_CORE_LSB = 4;
    localparam int FCR_PERIPH_LSB = 0;
    // =====================================================
    // strap encodings
    localparam logic [2:0] FCR_MODE_EXT_CLOCK = 3'h7;
    // =====================================================
    // sequencer states
    typedef enum logic [1:0] {
        FCR_RUN = 2'b01,
        FCR_SETTLE = 2'b10
    } fcr_state_e;
endpackage : fcr_pkg

// [verif/fcr_frequency_control_tb.sv]
// Purpose: self-checking bench for the frequency control register
// Assumes: one wait cycle per access, pins seen three cycles late
// Notes: integer model of register and active settings
`timescale 1ns/1ns
module fcr_frequency_control_tb;
    logic clk, rstn, read, write, watchdogOverflow, processorStatePinHi, processorStatePinLo;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, rd;
    logic [2:0] clockModePins;
    logic waitrequest, busClockPinOe, busClockHoldLow, processorPause, clocksStopped, watchdogStart;
    logic [1:0] pllMultiplier, coreDivider, periphDivider;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 32'h27a7;
    int regModel = 32'h1003;
    int actModel = 32'h1003;
    int v;
    logic [15:0] combo;
    logic [15:0] combos [12] = '{16'h1000, 16'h1001, 16'h1003, 16'h1101, 16'h1103, 16'h1111, 16'h1113,
        16'h1202, 16'h1222, 16'h1303, 16'h1313, 16'h1333};
    fcr_frequency_control dut_u (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .watchdogOverflow(watchdogOverflow), .clockModePins(clockModePins),
        .processorStatePinHi(processorStatePinHi), .processorStatePinLo(processorStatePinLo),
        .busClockPinOe(busClockPinOe), .busClockHoldLow(busClockHoldLow), .pllMultiplier(pllMultiplier),
        .coreDivider(coreDivider), .periphDivider(periphDivider), .processorPause(processorPause),
        .clocksStopped(clocksStopped), .watchdogStart(watchdogStart));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================
    // helpers
    task automatic print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd, input logic [3:0] be);
        int n;
        @(posedge clk);
        read <= ~wr;
        write <= wr;
        address <= addr;
        writedata <= wd;
        byteenable <= be;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        check(n, 2, "bus answer");
    endtask : bus
    task automatic checkAct(input logic busy);
        check({pllMultiplier, coreDivider, periphDivider}, {actModel[9:8], actModel[5:4], actModel[1:0]}, "act");
        check(processorPause, busy, "pause");
        check(clocksStopped, busy, "stopped");
    endtask : checkAct
    task automatic pickCombo(input logic [1:0] mul);
        do begin
            v = $random(seed);
            combo = combos[$unsigned(v) % 12];
        end while (combo[9:8] != mul);
    endtask : pickCombo
    task automatic wrChk(input logic [15:0] d);
        logic busy;
        bus(1'b1, 4'h0, {16'hA5A5, d}, 4'hF);
        regModel = d & 16'h1333;
        busy = regModel[9:8] != actModel[9:8];
        if (!busy) actModel = regModel;
        #1;
        checkAct(busy);
        check(watchdogStart, busy, "start");
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        check(rd, regModel, "readback");
    endtask : wrChk
    task automatic pins(input logic [2:0] m, input logic hi, input logic lo);
        @(posedge clk);
        clockModePins <= m;
        processorStatePinHi <= hi;
        processorStatePinLo <= lo;
        repeat (4) @(posedge clk);
        #1;
        check(busClockPinOe, m != 3'h7, "pin oe");
        check(busClockHoldLow, m != 3'h7 && !regModel[12] && !hi && lo, "hold low");
    endtask : pins
    // ==========================================
    // main sequence
    initial begin
        rstn = 1'b0;
        {read, write, watchdogOverflow, processorStatePinHi, processorStatePinLo} = 5'h00;
        address = 4'h0;
        byteenable = 4'hF;
        writedata = 32'h0;
        clockModePins = 3'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        #1;
        checkAct(1'b0);
        check(busClockPinOe, 1'b1, "oe reset");
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        check(rd, 32'h1003, "reset value");
        for (int i = 0; i < 6; i++) begin
            pickCombo(regModel[9:8]);
            wrChk((v[15:0] & 16'hFCCC) | (combo & 16'h0333));
        end
        for (int m = 1; m < 5; m++) begin
            pickCombo(m[1:0]);
            wrChk((v[15:0] & 16'hFCCC) | (combo & 16'h0333));
            #1;
            check(watchdogStart, 1'b0, "start pulse");
            @(posedge clk);
            watchdogOverflow <= 1'b1;
            @(posedge clk);
            watchdogOverflow <= 1'b0;
            #1;
            actModel = regModel;
            checkAct(1'b0);
        end
        @(posedge clk);
        watchdogOverflow <= 1'b1;
        @(posedge clk);
        watchdogOverflow <= 1'b0;
        #1;
        checkAct(1'b0);
        bus(1'b1, 4'h0, 32'h0, 4'h1);
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        check(rd, regModel, "byte write");
        bus(1'b0, 4'h0, 32'h0, 4'h2);
        check(rd, 32'h0, "byte read");
        bus(1'b1, 4'h5, 32'hFFFF, 4'hF);
        bus(1'b0, 4'h5, 32'h0, 4'hF);
        check(rd, 32'h0, "unmapped");
        wrChk(regModel[15:0] & 16'h0FFF);
        for (int i = 0; i < 16; i++) begin
            v = $random(seed);
            pins(i[2:0], v[0], v[1] | i[3]);
        end
        wrChk(regModel[15:0] | 16'h1000);
        pins(3'h0, 1'b0, 1'b1);
        print_verdict();
    end
endmodule : fcr_frequency_control_tb
